// ==== pmu_activity_map.svh ====
// Register indices, field positions, reset values and timing counts
`ifndef PMU_ACTIVITY_MAP_SVH
`define PMU_ACTIVITY_MAP_SVH
`define IDX_PMU_CONTROL     8'hc2
`define IDX_IO_RANGE_SELECT 8'hc5
`define IDX_RESUME_CONTROL  8'hdd
`define IDX_ACTIVITY_MASK   8'hdf
`define IDX_PMU_STATUS      8'he0
`define IDX_NMI_MASK        8'he1
`define IDX_NMI_STATUS      8'he2
`define CTL_RING_MSB        3
`define CTL_DEBOUNCE_BIT    7
`define ACT_KBD             0
`define ACT_SERIAL          1
`define ACT_CARD            2
`define ACT_DISK            3
`define ACT_GPIO            4
`define NMI_PRIMARY_LB      0
`define NMI_SECONDARY_LB    1
`define NMI_BUTTON          2
`define CTL_RST             8'h01
`define RANGE_RST           8'h00
`define RESUME_RST          8'h00
`define AMASK_RST           8'h1f
`define NMIMASK_RST         8'h07
`define KBD_PORT            16'h0060
`define SER_A_LO            16'h02e8
`define SER_A_HI            16'h02ef
`define SER_B_LO            16'h02f8
`define SER_B_HI            16'h02ff
`define SER_C_LO            16'h03e8
`define SER_C_HI            16'h03ef
`define SER_D_LO            16'h03f8
`define SER_D_HI            16'h03ff
`define DISK_A_LO           16'h03f6
`define DISK_A_HI           16'h03f7
`define DISK_B_LO           16'h01f0
`define DISK_B_HI           16'h01f7
`define CLK_HZ              100000000
`define TICK_US             500
`define TICK_CYC            (`CLK_HZ / 1000000 * `TICK_US)
`define BTN_LOW_US          60000
`define BTN_LOW_TICKS       (`BTN_LOW_US / `TICK_US)
`define BTN_STABLE_US       4000
`define BTN_STABLE_TICKS    (`BTN_STABLE_US / `TICK_US)
`define LB_MIN_US           1000
// One extra tick, as the first tick may fall right after the input rises
`define LB_MIN_TICKS        ((`LB_MIN_US + `TICK_US - 1) / `TICK_US + 1)
`define RSM_D0_US           250000
`define RSM_D1_US           125000
`define RSM_D2_US           62500
`define RSM_D3_US           0
`define AXI_OKAY            2'b00
`define AXI_SLVERR          2'b10
`endif

// ==== pmu_activity_pkg.sv ====
// Types shared by the activity and wake input block
package pmu_activity_pkg;
  typedef enum logic [2:0] {ST_ON, ST_DOZE, ST_SLEEP, ST_SUSPEND, ST_OFF} power_state_e;
  typedef enum logic [1:0] {RS_IDLE, RS_WAIT_GOOD, RS_DELAY, RS_RUN} resume_state_e;
endpackage : pmu_activity_pkg

// ==== pmu_activity_and_wake_inputs.sv ====
// Activity decoder and wake, reset, power-good and low-battery inputs
`timescale 1ns/1ns
`include "pmu_activity_map.svh"
module pmu_activity_and_wake_inputs
  import pmu_activity_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYC
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [11:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [11:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic         io_strobe,
  input  wire logic         io_write,
  input  wire logic [15:0]  io_addr,
  input  wire logic         card_io_hit,
  input  power_state_e      power_state,
  input  wire logic         power_button_input,
  input  wire logic         ring_indicator_input,
  input  wire logic         system_power_good,
  input  wire logic         hard_reset_input,
  input  wire logic         primary_low_battery,
  input  wire logic         secondary_low_battery,
  output logic [4:0]        activity_event,
  output logic              activity_any,
  output logic              wake_to_on,
  output logic              system_supply_enable,
  output logic              code_run_enable,
  output logic              system_reset_n,
  output logic              nmi
);

  function automatic logic in_win(input logic [15:0] a, input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction : in_win

  function automatic logic [7:0] reg_idx(input logic [11:0] a);
    reg_idx = a[9:2];
  endfunction : reg_idx

  function automatic logic mapped(input logic [11:0] a);
    logic [7:0] i;
    i = a[9:2];
    mapped = (a[11:10] == 2'b00) && (i == `IDX_PMU_CONTROL || i == `IDX_IO_RANGE_SELECT
             || i == `IDX_RESUME_CONTROL || i == `IDX_ACTIVITY_MASK || i == `IDX_PMU_STATUS
             || i == `IDX_NMI_MASK || i == `IDX_NMI_STATUS);
  endfunction : mapped

  // Pin synchronisers, stage one read only by stage two
  logic [5:0] pin_meta_r;
  logic [5:0] pin_sync_r;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_meta_r <= 6'h07;
      pin_sync_r <= 6'h07;
    end
    else
    begin
      pin_meta_r <= {secondary_low_battery, primary_low_battery, system_power_good,
                     ring_indicator_input, power_button_input, hard_reset_input};
      pin_sync_r <= pin_meta_r;
    end
  end
  logic hr_s, btn_s, ring_s, pg_s, lb1_s, lb2_s, srst;
  assign {lb2_s, lb1_s, pg_s, ring_s, btn_s, hr_s} = pin_sync_r;
  assign srst = !hr_s;
  assign system_reset_n = hr_s;

  logic asleep, awake;
  assign asleep = (power_state == ST_SUSPEND) || (power_state == ST_OFF);
  assign awake  = !asleep;

  logic [15:0] tick_cnt_r;
  logic        tick;
  assign tick = (tick_cnt_r == 16'(TICK_CYCLES - 1));
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      tick_cnt_r <= 16'h0000;
    else if (tick)
      tick_cnt_r <= 16'h0000;
    else
      tick_cnt_r <= tick_cnt_r + 16'h0001;
  end

  // Registers
  logic [7:0] ctl_r, range_r, resume_r, amask_r, nmimask_r, nmistat_r;
  logic [2:0] nmi_set;
  logic       wr_fire, aw_held_r, w_held_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_lane;
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_lane = wr_fire && wstrb_r[0] && mapped(awaddr_r);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctl_r     <= `CTL_RST;
      range_r   <= `RANGE_RST;
      resume_r  <= `RESUME_RST;
      amask_r   <= `AMASK_RST;
      nmimask_r <= `NMIMASK_RST;
    end
    else if (srst)
    begin
      ctl_r     <= `CTL_RST;
      range_r   <= `RANGE_RST;
      resume_r  <= `RESUME_RST;
      amask_r   <= `AMASK_RST;
      nmimask_r <= `NMIMASK_RST;
    end
    else if (wr_lane)
    begin
      case (reg_idx(awaddr_r))
        `IDX_PMU_CONTROL:     ctl_r     <= wdata_r[7:0];
        `IDX_IO_RANGE_SELECT: range_r   <= wdata_r[7:0];
        `IDX_RESUME_CONTROL:  resume_r  <= wdata_r[7:0];
        `IDX_ACTIVITY_MASK:   amask_r   <= wdata_r[7:0];
        `IDX_NMI_MASK:        nmimask_r <= wdata_r[7:0];
        default:              ;
      endcase
    end
  end

  // pending bits, write one to clear, set wins
  logic [7:0] nmi_clr;
  assign nmi_clr = (wr_lane && reg_idx(awaddr_r) == `IDX_NMI_STATUS) ? wdata_r[7:0] : 8'h00;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      nmistat_r <= 8'h00;
    else if (srst)
      nmistat_r <= 8'h00;
    else
      nmistat_r <= (nmistat_r & ~nmi_clr) | {5'h00, nmi_set};
  end
  assign nmi = |(nmistat_r[2:0] & ~nmimask_r[2:0]);

  // AXI write channel
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready  = !w_held_r;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      awaddr_r     <= 12'h000;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_r) ? `AXI_OKAY : `AXI_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // AXI read channel
  logic [7:0] status_v;
  logic [7:0] rd_v;
  assign status_v = {power_state, 1'b0, lb2_s, lb1_s, code_run_enable, system_supply_enable};
  always_comb
  begin
    case (reg_idx(s_axi_araddr))
      `IDX_PMU_CONTROL:     rd_v = ctl_r;
      `IDX_IO_RANGE_SELECT: rd_v = range_r;
      `IDX_RESUME_CONTROL:  rd_v = resume_r;
      `IDX_ACTIVITY_MASK:   rd_v = amask_r;
      `IDX_PMU_STATUS:      rd_v = status_v;
      `IDX_NMI_MASK:        rd_v = nmimask_r;
      `IDX_NMI_STATUS:      rd_v = nmistat_r;
      default:              rd_v = 8'h00;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `AXI_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= mapped(s_axi_araddr) ? {24'h000000, rd_v} : 32'h0000_0000;
      s_axi_rresp  <= mapped(s_axi_araddr) ? `AXI_OKAY : `AXI_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Activity decode
  logic [4:0] act_raw;
  always_comb
  begin
    act_raw = 5'h00;
    act_raw[`ACT_KBD] = io_strobe && !io_write && (io_addr == `KBD_PORT);
    act_raw[`ACT_SERIAL] = io_strobe && (in_win(io_addr, `SER_A_LO, `SER_A_HI)
      || in_win(io_addr, `SER_B_LO, `SER_B_HI) || in_win(io_addr, `SER_C_LO, `SER_C_HI)
      || in_win(io_addr, `SER_D_LO, `SER_D_HI));
    act_raw[`ACT_CARD] = io_strobe && card_io_hit;
    act_raw[`ACT_DISK] = io_strobe && (in_win(io_addr, `DISK_A_LO, `DISK_A_HI)
      || in_win(io_addr, `DISK_B_LO, `DISK_B_HI));
    act_raw[`ACT_GPIO] = io_strobe && (io_addr[15:10] == 6'h00) && (io_addr[9:2] == range_r);
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      activity_event <= 5'h00;
      activity_any   <= 1'b0;
    end
    else
    begin
      activity_event <= act_raw & amask_r[4:0];
      activity_any   <= |(act_raw & amask_r[4:0]);
    end
  end

  logic [3:0] btn_stab_r;
  logic [7:0] btn_low_r;
  logic       btn_db_r, btn_rise, btn_long;
  assign btn_rise = tick && !btn_db_r && btn_s && (btn_stab_r == 4'(`BTN_STABLE_TICKS - 1));
  assign btn_long = btn_low_r > 8'(`BTN_LOW_TICKS);
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      btn_stab_r <= 4'h0;
      btn_db_r   <= 1'b1;
      btn_low_r  <= 8'h00;
    end
    else if (tick)
    begin
      if (btn_s == btn_db_r)
        btn_stab_r <= 4'h0;
      else if (btn_stab_r == 4'(`BTN_STABLE_TICKS - 1))
      begin
        btn_stab_r <= 4'h0;
        btn_db_r   <= btn_s;
      end
      else
        btn_stab_r <= btn_stab_r + 4'h1;
      if (btn_db_r)
        btn_low_r <= 8'h00;
      else if (btn_low_r != 8'hff)
        btn_low_r <= btn_low_r + 8'h01;
    end
  end
  logic btn_wake, btn_nmi;
  assign btn_wake = btn_rise && btn_long && (power_state == ST_SUSPEND);
  // release after long press requests power-down
  assign btn_nmi  = btn_rise && btn_long && awake;

  logic       ring_prev_r;
  logic [3:0] ring_cnt_r;
  logic       ring_edge, ring_wake;
  assign ring_edge = ring_s && !ring_prev_r && asleep;
  assign ring_wake = ring_edge && (ring_cnt_r + 4'h1 >= ctl_r[`CTL_RING_MSB:0]);
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ring_prev_r <= 1'b1;
      ring_cnt_r  <= 4'h0;
    end
    else
    begin
      ring_prev_r <= ring_s;
      if (srst || awake || ring_wake)
        ring_cnt_r <= 4'h0;
      else if (ring_edge)
        ring_cnt_r <= ring_cnt_r + 4'h1;
    end
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wake_to_on <= 1'b0;
    else
      wake_to_on <= !srst && (btn_wake || ring_wake);
  end

  // Low battery inputs
  logic [1:0] lb_in, lb_prev_r, lb_done_r, lb_ev;
  logic [1:0] lb_cnt_r [2];
  assign lb_in = {lb2_s && awake, lb1_s};
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lb_prev_r <= 2'b00;
      lb_done_r <= 2'b00;
      lb_cnt_r  <= '{2'b00, 2'b00};
    end
    else
    begin
      lb_prev_r <= lb_in;
      for (int i = 0; i < 2; i++)
      begin
        if (!lb_in[i])
        begin
          lb_cnt_r[i]  <= 2'b00;
          lb_done_r[i] <= 1'b0;
        end
        else if (tick && lb_cnt_r[i] != 2'(`LB_MIN_TICKS))
          lb_cnt_r[i] <= lb_cnt_r[i] + 2'b01;
        else if (lb_cnt_r[i] == 2'(`LB_MIN_TICKS))
          lb_done_r[i] <= 1'b1;
      end
    end
  end
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (ctl_r[`CTL_DEBOUNCE_BIT])
        lb_ev[i] = lb_in[i] && !lb_done_r[i] && (lb_cnt_r[i] == 2'(`LB_MIN_TICKS));
      else
        lb_ev[i] = lb_in[i] && !lb_prev_r[i];
    end
  end
  assign nmi_set = {btn_nmi, lb_ev};

  logic asleep_prev_r, sleep_entry;
  assign sleep_entry = asleep && !asleep_prev_r;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      asleep_prev_r        <= 1'b0;
      system_supply_enable <= 1'b1;
    end
    else
    begin
      asleep_prev_r <= asleep;
      if (srst || wake_to_on)
        system_supply_enable <= 1'b1;
      else if (sleep_entry)
        system_supply_enable <= 1'b0;
    end
  end

  resume_state_e rs_r;
  logic [9:0]    rs_cnt_r;
  logic          cold_r;
  logic [9:0]    rs_load;
  always_comb
  begin
    case (cold_r ? 2'b00 : resume_r[1:0])
      2'b00:   rs_load = 10'(`RSM_D0_US / `TICK_US);
      2'b01:   rs_load = 10'(`RSM_D1_US / `TICK_US);
      2'b10:   rs_load = 10'(`RSM_D2_US / `TICK_US);
      default: rs_load = 10'(`RSM_D3_US / `TICK_US);
    endcase
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rs_r     <= RS_WAIT_GOOD;
      rs_cnt_r <= 10'h000;
      cold_r   <= 1'b1;
    end
    else if (srst)
    begin
      rs_r     <= RS_WAIT_GOOD;
      rs_cnt_r <= 10'h000;
      cold_r   <= 1'b1;
    end
    else if (wake_to_on)
      rs_r <= RS_WAIT_GOOD;
    else if (sleep_entry)
      rs_r <= RS_IDLE;
    else
    begin
      case (rs_r)
        RS_IDLE:
          rs_r <= RS_IDLE;
        RS_WAIT_GOOD:
          if (pg_s)
          begin
            rs_cnt_r <= rs_load;
            rs_r     <= RS_DELAY;
          end
        RS_DELAY:
          if (!pg_s)
            rs_r <= RS_WAIT_GOOD;
          else if (rs_cnt_r == 10'h000)
          begin
            rs_r   <= RS_RUN;
            cold_r <= 1'b0;
          end
          else if (tick)
            rs_cnt_r <= rs_cnt_r - 10'h001;
        RS_RUN:
          rs_r <= RS_RUN;
        default:
          rs_r <= RS_IDLE;
      endcase
    end
  end
  assign code_run_enable = (rs_r == RS_RUN);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_kbd_read_only: assert property (io_strobe && io_write |=> !activity_event[`ACT_KBD])
    else $error("keyboard write flagged");
  a_serial_window: assert property (io_strobe && amask_r[`ACT_SERIAL]
    && (io_addr inside {[`SER_A_LO:`SER_A_HI], [`SER_B_LO:`SER_B_HI],
                        [`SER_C_LO:`SER_C_HI], [`SER_D_LO:`SER_D_HI]})
    |=> activity_event[`ACT_SERIAL])
    else $error("serial access missed");
  a_disk_window: assert property (io_strobe && amask_r[`ACT_DISK]
    && (io_addr inside {[`DISK_A_LO:`DISK_A_HI], [`DISK_B_LO:`DISK_B_HI]})
    |=> activity_event[`ACT_DISK])
    else $error("disk access missed");
  a_card_mask: assert property (!amask_r[`ACT_CARD] |=> !activity_event[`ACT_CARD])
    else $error("masked card activity");
  a_activity_pulse: assert property (activity_any |=> !activity_any || $past(io_strobe))
    else $error("activity pulse too long");
  a_button_wake: assert property (btn_wake && !srst |=> wake_to_on ##1 system_supply_enable)
    else $error("button wake lost");
  a_button_nmi: assert property (btn_nmi |=> nmistat_r[`NMI_BUTTON])
    else $error("button nmi lost");
  a_lb2_asleep: assert property (asleep && !ctl_r[`CTL_DEBOUNCE_BIT] |-> !lb_ev[1])
    else $error("secondary battery seen asleep");
  a_lb_edge: assert property (!ctl_r[`CTL_DEBOUNCE_BIT] && $rose(lb1_s) && !srst
    |=> nmistat_r[`NMI_PRIMARY_LB])
    else $error("edge nmi lost");
  a_lb_hold: assert property (ctl_r[`CTL_DEBOUNCE_BIT] && lb_ev[1]
    |-> lb2_s && $past(lb2_s, 3))
    else $error("debounced nmi too early");
  a_hard_reset: assert property (srst |=> ctl_r == `CTL_RST && nmistat_r == 8'h00)
    else $error("hard reset ignored");
  a_run_waits_good: assert property (code_run_enable && !$past(code_run_enable)
    |-> $past(pg_s))
    else $error("run before power good");
  a_cold_delay: assert property (cold_r && rs_r == RS_WAIT_GOOD && pg_s && !srst
    && !wake_to_on && !sleep_entry |=> rs_cnt_r == 10'(`RSM_D0_US / `TICK_US))
    else $error("cold delay not 250 ms");

  c_wake_ring: cover property (ring_wake);
  c_run_start: cover property ($rose(code_run_enable));
  c_nmi_raised: cover property ($rose(nmi));
  c_gpio_hit: cover property (activity_event[`ACT_GPIO]);

endmodule : pmu_activity_and_wake_inputs

// ==== pmu_far_side.sv ====
// Far-side model: power switch, button, modem ring, battery supervisors
`timescale 1ns/1ns
module pmu_far_side #(
  parameter int PG_DELAY = 20
) (
  input  wire logic clk,
  input  wire logic system_supply_enable,
  output logic      power_button_input,
  output logic      ring_indicator_input,
  output logic      system_power_good,
  output logic      primary_low_battery,
  output logic      secondary_low_battery
);
  int on_cnt = 0;
  initial
  begin
    power_button_input = 1'b1;
    ring_indicator_input = 1'b1;
    system_power_good = 1'b0;
    primary_low_battery = 1'b0;
    secondary_low_battery = 1'b0;
  end
  always @(posedge clk)
  begin
    on_cnt <= system_supply_enable ? on_cnt + 1 : 0;
    system_power_good <= (on_cnt >= PG_DELAY);
  end
  task automatic press(input int n);
    repeat (3)
    begin
      @(posedge clk) power_button_input <= 1'b0;
      @(posedge clk) power_button_input <= 1'b1;
    end
    @(posedge clk) power_button_input <= 1'b0;
    repeat (n) @(posedge clk);
    power_button_input <= 1'b1;
  endtask : press
  task automatic ring(input int n);
    repeat (n)
    begin
      @(posedge clk) ring_indicator_input <= 1'b0;
      repeat (8) @(posedge clk);
      ring_indicator_input <= 1'b1;
      repeat (8) @(posedge clk);
    end
  endtask : ring
  task automatic lb(input logic p, input logic s);
    @(posedge clk);
    primary_low_battery <= p;
    secondary_low_battery <= s;
  endtask : lb
endmodule : pmu_far_side

// ==== pmu_activity_and_wake_inputs_tb.sv ====
// Self-checking bench for the activity and wake input block
`timescale 1ns/1ns
`include "pmu_activity_map.svh"
module pmu_activity_and_wake_inputs_tb
  import pmu_activity_pkg::*;
;
  localparam logic [7:0] CTL = `IDX_PMU_CONTROL, RNG = `IDX_IO_RANGE_SELECT;
  localparam logic [7:0] RSM = `IDX_RESUME_CONTROL, AMK = `IDX_ACTIVITY_MASK;
  localparam logic [7:0] STA = `IDX_PMU_STATUS, NMK = `IDX_NMI_MASK, NST = `IDX_NMI_STATUS;
  localparam logic [1:0] OK = `AXI_OKAY, ER = `AXI_SLVERR;
  logic         clk = 1'b0, reset_n = 1'b0, hard_reset_input = 1'b1;
  logic [11:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]  s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]   s_axi_wstrb = 4'hf;
  logic         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic         s_axi_arvalid = 0, s_axi_rready = 0;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic         io_strobe = 0, io_write = 0, card_io_hit = 0;
  logic [15:0]  io_addr = '0;
  power_state_e power_state = ST_ON;
  logic         power_button_input, ring_indicator_input, system_power_good;
  logic         primary_low_battery, secondary_low_battery;
  logic [4:0]   activity_event;
  logic         activity_any, wake_to_on, system_supply_enable, code_run_enable;
  logic         system_reset_n, nmi;
  int           fails = 0, comparisons = 0, cycles = 0, wakes = 0, w;

  pmu_activity_and_wake_inputs #(.TICK_CYCLES(4)) DUT (
    .clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .io_strobe, .io_write, .io_addr,
    .card_io_hit, .power_state, .power_button_input, .ring_indicator_input,
    .system_power_good, .hard_reset_input, .primary_low_battery,
    .secondary_low_battery, .activity_event, .activity_any, .wake_to_on,
    .system_supply_enable, .code_run_enable, .system_reset_n, .nmi);
  pmu_far_side far (
    .clk, .system_supply_enable, .power_button_input, .ring_indicator_input,
    .system_power_good, .primary_low_battery, .secondary_low_battery);

  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (wake_to_on === 1'b1) wakes++;
    if (cycles > 15000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic axw(input logic [7:0] i, input logic [7:0] v, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= {2'b00, i, 2'b00};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask : axw

  task automatic rd(input logic [7:0] i, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= {2'b00, i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask : rd

  task automatic io(input logic wr, input logic [15:0] a, input logic c, input logic [4:0] e);
    @(posedge clk);
    io_strobe <= 1'b1;
    io_write <= wr;
    io_addr <= a;
    card_io_hit <= c;
    @(posedge clk);
    io_strobe <= 1'b0;
    #1;
    chk("activity_event", e, activity_event);
    chk("activity_any", |e, activity_any);
  endtask : io

  // Cycles until execution may run, within a window
  task automatic wrun(input int lo, input int hi);
    int n;
    n = 0;
    while (code_run_enable !== 1'b1 && n < hi)
    begin
      @(posedge clk);
      n++;
    end
    chk("run_delay_ok", 1, n >= lo && n < hi);
  endtask : wrun

  task automatic tally_and_finish();
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    wrun(1990, 2100);
    rd(CTL, 8'h01, OK);
    rd(RNG, 0, OK);
    rd(RSM, 0, OK);
    rd(AMK, 8'h1f, OK);
    rd(NMK, 8'h07, OK);
    rd(STA, 8'h03, OK);
    axw(STA, 8'hff, OK);
    rd(STA, 8'h03, OK);
    rd(8'h00, 0, ER);
    axw(8'h00, 8'h5a, ER);
    axw(RNG, 8'h40, OK);
    s_axi_wstrb <= 4'he;
    axw(RNG, 8'h55, OK);
    s_axi_wstrb <= 4'hf;
    rd(RNG, 8'h40, OK);
    io(0, `KBD_PORT, 0, 5'h01);
    io(1, `KBD_PORT, 0, 5'h00);
    io(1, `SER_A_LO, 0, 5'h02);
    io(0, `SER_B_HI, 0, 5'h02);
    io(1, `SER_C_HI, 0, 5'h02);
    io(0, `SER_D_LO, 0, 5'h02);
    io(0, 16'h02f0, 0, 5'h00);
    io(1, `DISK_A_LO, 0, 5'h08);
    io(0, `DISK_B_HI, 0, 5'h08);
    io(0, 16'h01f8, 0, 5'h00);
    io(0, 16'h0100, 0, 5'h10);
    io(1, 16'h0103, 0, 5'h10);
    io(0, 16'h0104, 0, 5'h00);
    io(1, 16'h0200, 1, 5'h04);
    axw(AMK, 8'h1b, OK);
    io(1, 16'h0200, 1, 5'h00);
    io(0, `KBD_PORT, 0, 5'h01);
    axw(NMK, 8'h00, OK);
    far.press(320);
    repeat (60) @(posedge clk);
    rd(NST, 0, OK);
    power_state <= ST_DOZE;
    far.press(600);
    repeat (60) @(posedge clk);
    rd(NST, 8'h04, OK);
    power_state <= ST_ON;
    chk("nmi", 1, nmi);
    axw(NST, 8'h04, OK);
    far.lb(1, 0);
    repeat (6) @(posedge clk);
    chk("nmi", 1, nmi);
    rd(STA, 8'h07, OK);
    rd(NST, 8'h01, OK);
    axw(NST, 8'h01, OK);
    rd(NST, 0, OK);
    far.lb(0, 0);
    axw(CTL, 8'h81, OK);
    far.lb(0, 1);
    repeat (6) @(posedge clk);
    far.lb(0, 0);
    repeat (20) @(posedge clk);
    rd(NST, 0, OK);
    far.lb(0, 1);
    repeat (20) @(posedge clk);
    rd(NST, 8'h02, OK);
    far.lb(0, 0);
    axw(NST, 8'h02, OK);
    axw(RSM, 8'h03, OK);
    axw(CTL, 8'h03, OK);
    power_state <= ST_OFF;
    repeat (10) @(posedge clk);
    chk("supply", 0, system_supply_enable);
    far.lb(0, 1);
    repeat (20) @(posedge clk);
    rd(NST, 0, OK);
    far.lb(0, 0);
    w = wakes;
    far.ring(2);
    chk("wakes", w, wakes);
    far.ring(1);
    chk("wakes", w + 1, wakes);
    chk("supply", 1, system_supply_enable);
    wrun(0, 60);
    @(posedge clk);
    power_state <= ST_ON;
    axw(RSM, 8'h01, OK);
    power_state <= ST_SUSPEND;
    repeat (10) @(posedge clk);
    w = wakes;
    far.press(600);
    wrun(1000, 1150);
    chk("wakes", w + 1, wakes);
    @(posedge clk);
    power_state <= ST_ON;
    hard_reset_input <= 1'b0;
    repeat (4) @(posedge clk);
    chk("system_reset_n", 0, system_reset_n);
    chk("run", 0, code_run_enable);
    hard_reset_input <= 1'b1;
    repeat (6) @(posedge clk);
    rd(RNG, 0, OK);
    rd(NMK, 8'h07, OK);
    tally_and_finish();
  end
endmodule : pmu_activity_and_wake_inputs_tb
